// file: hw/iifs_defs.vh
`ifndef IIFS_DEFS_VH
`define IIFS_DEFS_VH

// ----------------------------------------------------------------
// Fixed values
// ----------------------------------------------------------------
`define IIFS_FALLBACK_ADDR   7'h7C
`define IIFS_MEM_FAULT_BIT   4
`define IIFS_CML_W           8
// Fault response codes
`define IIFS_RESP_LATCH      2'h1
`define IIFS_RESP_IGNORE     2'h2
`define IIFS_RESP_HICCUP     2'h3
`define IIFS_RESP_NONE       2'h0
// Command select codes of the response settings
`define IIFS_SEL_UV          2'h0
`define IIFS_SEL_OV          2'h1
`define IIFS_SEL_PEAK        2'h2
// Reset defaults of the response settings
`define IIFS_OV_RESP_RST     2'h1
`define IIFS_UV_RESP_RST     2'h2
`define IIFS_PEAK_RESP_RST   2'h2
// Init sequencer states
`define IIFS_ST_OFF          3'h0
`define IIFS_ST_START        3'h1
`define IIFS_ST_ADDR         3'h2
`define IIFS_ST_LOAD         3'h3
`define IIFS_ST_CRC          3'h4
`define IIFS_ST_CAL          3'h5
`define IIFS_ST_WAIT         3'h6
`define IIFS_ST_READY        3'h7
// Init and hiccup times, in microseconds, and clock in MHz
`define IIFS_T_INIT_US       100
`define IIFS_CLK_MHZ         25
`define IIFS_HICCUP_US       40

`endif

// file: hw/iifs_supervisor.v
// What this block does
// - System register changes apply only after supply cycle
// - Bus settings take effect once in RAM
// - Separate locks for writes, critical, cpu-link, NVM
// - Supply above lockout starts fixed-order init sequence
// - Bad strap blocks conversion, uses fallback address
// - Init copies NVM defaults into working RAM
// - CRC mismatch blocks, sets memory fault, fallback
// - Self-calibration is the last init step
// - Enable and commands accepted only after init time
// - Enable below turn-on threshold reports undervoltage
// - Input rising above threshold starts conversion itself
// - Turn-on threshold checked only on first enable
// - Input watched against undervoltage and overvoltage limits
// - Responses are latch, ignore or hiccup restart
// - Reset defaults overvoltage latch, undervoltage ignore
// - Peak input fault with latch or ignore response
// - Peak response defaults to ignore after reset
// - Latched faults held until clear or re-enable
`timescale 1ns/1ps
`include "iifs_defs.vh"

module iifs_supervisor #(
  parameter T_INIT_CYC = `IIFS_T_INIT_US * `IIFS_CLK_MHZ,
  parameter HICCUP_CYC = `IIFS_HICCUP_US * `IIFS_CLK_MHZ
) (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       controller_supply_ok,
  input  wire       strap_valid,
  input  wire [6:0] strap_addr,
  input  wire       nvm_load_done,
  input  wire       crc_match,
  input  wire       cal_done,
  input  wire       output_enable_req,
  input  wire       vin_above_on,
  input  wire       vin_under_limit,
  input  wire       vin_over_limit,
  input  wire       input_sense_peak,
  input  wire       clear_faults,
  input  wire       cmd_write,
  input  wire [1:0] cmd_sel,
  input  wire [1:0] cmd_data,
  input  wire       sysreg_write,
  input  wire       sysreg_critical,
  input  wire       sysreg_cpu_link,
  input  wire       nvm_write_req,
  input  wire       general_write_lock,
  input  wire       critical_access_unlock,
  input  wire       cpu_link_register_lock,
  input  wire       nvm_write_guard,
  output reg        nvm_load_start,
  output reg        crc_start,
  output reg        cal_start,
  output reg        init_done,
  output reg        bus_accept,
  output reg  [6:0] bus_addr,
  output reg        conv_blocked,
  output reg        converting,
  output reg  [`IIFS_CML_W-1:0] cml_status,
  output reg        vin_uv_fault,
  output reg        vin_ov_fault,
  output reg        vin_peak_fault,
  output reg        sysreg_pending,
  output reg        cmd_write_ok,
  output reg        nvm_write_ok
);

  // ----------------------------------------------------------------
  // Input synchronisers: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  localparam NSYNC = 6;
  wire [NSYNC-1:0] raw_in = {input_sense_peak, vin_over_limit,
                             vin_under_limit, vin_above_on,
                             output_enable_req, controller_supply_ok};
  reg  [NSYNC-1:0] s1_reg;         // Metastability catcher only
  reg  [NSYNC-1:0] s2_reg;
  reg  [NSYNC-1:0] s3_reg;
  reg  [NSYNC-1:0] filt_reg;       // Filtered level
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // Hold previous level until the last two stages agree
      always @(posedge clock) begin
        if (sys_rst) begin
          s1_reg[gi]   <= 1'b0;
          s2_reg[gi]   <= 1'b0;
          s3_reg[gi]   <= 1'b0;
          filt_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= raw_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate
  wire supply_ok = filt_reg[0];
  wire en_req    = filt_reg[1];
  wire vin_on    = filt_reg[2];
  wire uv_hit    = filt_reg[3];
  wire ov_hit    = filt_reg[4];
  wire peak_hit  = filt_reg[5];

  // ----------------------------------------------------------------
  // Initialization sequencer
  // ----------------------------------------------------------------
  reg [2:0]  state_reg;            // Sequencer state
  reg [2:0]  state_next;
  reg [31:0] tinit_reg;            // Cycles since sequence start
  reg        strap_bad_reg;        // Latched bad strap
  reg        crc_bad_reg;          // Latched CRC failure

  // Next-state decode; steps run in a fixed order
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `IIFS_ST_OFF:   if (supply_ok) state_next = `IIFS_ST_START;
      `IIFS_ST_START: state_next = `IIFS_ST_ADDR;
      `IIFS_ST_ADDR:  state_next = `IIFS_ST_LOAD;
      `IIFS_ST_LOAD:  if (nvm_load_done) state_next = `IIFS_ST_CRC;
      `IIFS_ST_CRC:   state_next = `IIFS_ST_CAL;
      `IIFS_ST_CAL:   if (cal_done) state_next = `IIFS_ST_WAIT;
      `IIFS_ST_WAIT: begin
        if (tinit_reg >= T_INIT_CYC - 1) begin
          state_next = `IIFS_ST_READY;
        end
      end
      default:        state_next = `IIFS_ST_READY;
    endcase
    // Supply loss always restarts the whole sequence
    if (!supply_ok) begin
      state_next = `IIFS_ST_OFF;
    end
  end

  // Sequencer registers, strobes and address selection
  always @(posedge clock) begin
    if (sys_rst) begin
      state_reg      <= `IIFS_ST_OFF;
      tinit_reg      <= 32'h0;
      strap_bad_reg  <= 1'b0;
      crc_bad_reg    <= 1'b0;
      nvm_load_start <= 1'b0;
      crc_start      <= 1'b0;
      cal_start      <= 1'b0;
      init_done      <= 1'b0;
      bus_accept     <= 1'b0;
      bus_addr       <= `IIFS_FALLBACK_ADDR;
      conv_blocked   <= 1'b0;
      cml_status     <= {`IIFS_CML_W{1'b0}};
    end else begin
      state_reg      <= state_next;
      // One-cycle strobes on entry to the load, check and calibration steps
      nvm_load_start <= (state_reg == `IIFS_ST_ADDR);
      crc_start      <= (state_reg == `IIFS_ST_LOAD) && nvm_load_done;
      cal_start      <= (state_reg == `IIFS_ST_CRC);
      if (state_reg == `IIFS_ST_OFF) begin
        tinit_reg <= 32'h0;
      end else if (state_reg != `IIFS_ST_READY) begin
        tinit_reg <= tinit_reg + 32'h1;
      end
      if (state_reg == `IIFS_ST_OFF) begin
        strap_bad_reg <= 1'b0;
        crc_bad_reg   <= 1'b0;
        cml_status    <= {`IIFS_CML_W{1'b0}};
      end
      if (state_reg == `IIFS_ST_ADDR) begin
        strap_bad_reg <= !strap_valid;
        if (strap_valid) begin
          bus_addr <= strap_addr;
        end else begin
          bus_addr <= `IIFS_FALLBACK_ADDR;
        end
      end
      if (state_reg == `IIFS_ST_CRC && !crc_match) begin
        crc_bad_reg <= 1'b1;
        cml_status[`IIFS_MEM_FAULT_BIT] <= 1'b1;
        bus_addr    <= `IIFS_FALLBACK_ADDR;
      end else if (clear_faults && state_reg == `IIFS_ST_READY) begin
        cml_status[`IIFS_MEM_FAULT_BIT] <= 1'b0;
      end
      conv_blocked <= strap_bad_reg || crc_bad_reg;
      init_done    <= (state_next == `IIFS_ST_READY);
      // Bus answers once ready, even when blocked
      bus_accept   <= (state_next == `IIFS_ST_READY);
    end
  end

  // ----------------------------------------------------------------
  // Settings held in working RAM and access protection
  // ----------------------------------------------------------------
  reg [1:0] uv_resp_reg;           // Undervoltage response
  reg [1:0] ov_resp_reg;           // Overvoltage response
  reg [1:0] peak_resp_reg;         // Peak response
  wire ready = (state_reg == `IIFS_ST_READY);
  wire wr_ok = ready && cmd_write && !general_write_lock;

  // Bus writes act at once on RAM copies; restore on reset
  always @(posedge clock) begin
    if (sys_rst) begin
      uv_resp_reg    <= `IIFS_UV_RESP_RST;
      ov_resp_reg    <= `IIFS_OV_RESP_RST;
      peak_resp_reg  <= `IIFS_PEAK_RESP_RST;
      sysreg_pending <= 1'b0;
      cmd_write_ok   <= 1'b0;
      nvm_write_ok   <= 1'b0;
    end else begin
      cmd_write_ok <= wr_ok;
      nvm_write_ok <= ready && nvm_write_req && !nvm_write_guard;
      if (state_reg == `IIFS_ST_LOAD) begin
        // NVM load replaces defaults; a new power cycle clears pending
        sysreg_pending <= 1'b0;
      end else if (ready && sysreg_write
                   && (!sysreg_critical || critical_access_unlock)
                   && (!sysreg_cpu_link || !cpu_link_register_lock)) begin
        // System register edits wait for the next supply cycle
        sysreg_pending <= 1'b1;
      end
      if (wr_ok) begin
        case (cmd_sel)
          `IIFS_SEL_UV: if (cmd_data != `IIFS_RESP_NONE) begin
            uv_resp_reg <= cmd_data;
          end
          `IIFS_SEL_OV: if (cmd_data != `IIFS_RESP_NONE) begin
            ov_resp_reg <= cmd_data;
          end
          `IIFS_SEL_PEAK: begin
            // Peak fault has no hiccup option
            if (cmd_data == `IIFS_RESP_LATCH ||
                cmd_data == `IIFS_RESP_IGNORE) begin
              peak_resp_reg <= cmd_data;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Input faults and conversion gating
  // ----------------------------------------------------------------
  reg        first_done_reg;       // A first enable has succeeded
  reg        latched_reg;          // Latched shutdown in force
  reg        en_prev_reg;          // Enable of the last cycle
  reg [31:0] hic_reg;              // Hiccup hold-off counter
  // Supply term drops conversion in step with init_done on supply loss
  wire en_ok    = ready && supply_ok && en_req && !conv_blocked;
  wire en_rise  = en_req && !en_prev_reg;
  wire thr_ok   = vin_on || first_done_reg;
  wire uv_latch = uv_hit && uv_resp_reg == `IIFS_RESP_LATCH;
  wire ov_latch = ov_hit && ov_resp_reg == `IIFS_RESP_LATCH;
  wire pk_latch = peak_hit && peak_resp_reg == `IIFS_RESP_LATCH;
  wire hic_trip = (uv_hit && uv_resp_reg == `IIFS_RESP_HICCUP) ||
                  (ov_hit && ov_resp_reg == `IIFS_RESP_HICCUP);

  // Fault flags set wins over clear; latch held until clear or re-enable
  always @(posedge clock) begin
    if (sys_rst) begin
      first_done_reg <= 1'b0;
      latched_reg    <= 1'b0;
      en_prev_reg    <= 1'b0;
      hic_reg        <= 32'h0;
      converting     <= 1'b0;
      vin_uv_fault   <= 1'b0;
      vin_ov_fault   <= 1'b0;
      vin_peak_fault <= 1'b0;
    end else begin
      en_prev_reg <= en_req;
      if (state_reg == `IIFS_ST_OFF) begin
        first_done_reg <= 1'b0;
      end else if (converting) begin
        first_done_reg <= 1'b1;
      end
      if (uv_hit || (en_ok && !thr_ok)) begin
        vin_uv_fault <= 1'b1;
      end else if (clear_faults || en_rise) begin
        vin_uv_fault <= 1'b0;
      end
      if (ov_hit) begin
        vin_ov_fault <= 1'b1;
      end else if (clear_faults || en_rise) begin
        vin_ov_fault <= 1'b0;
      end
      if (peak_hit) begin
        vin_peak_fault <= 1'b1;
      end else if (clear_faults || en_rise) begin
        vin_peak_fault <= 1'b0;
      end
      if (uv_latch || ov_latch || pk_latch) begin
        latched_reg <= 1'b1;
      end else if (clear_faults || en_rise) begin
        latched_reg <= 1'b0;
      end
      if (hic_trip) begin
        hic_reg <= HICCUP_CYC;
      end else if (hic_reg != 32'h0) begin
        hic_reg <= hic_reg - 32'h1;
      end
      // Waiting below threshold starts on its own when input rises
      converting <= en_ok && thr_ok && !latched_reg && !hic_trip
                    && (hic_reg == 32'h0)
                    && !uv_latch && !ov_latch && !pk_latch;
    end
  end

endmodule

// file: testbench/iifs_nvm_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------
// Memory loader and calibrator answering the sequencer
// ------------------------------------------------------
module iifs_nvm_model #(
  parameter [3:0] DLY = 4'h3
) (
  input  wire clock,
  input  wire nvm_load_start,
  input  wire cal_start,
  output reg  nvm_load_done = 1'b0,
  output reg  cal_done = 1'b0
);
  reg [3:0] load_cnt_reg = 4'h0; // Cycles left in the copy
  reg [3:0] cal_cnt_reg  = 4'h0; // Cycles left in calibration
  // Done is a single pulse, so a sequencer that waits on a level hangs
  always @(posedge clock) begin
    nvm_load_done <= (load_cnt_reg == 4'h1);
    cal_done      <= (cal_cnt_reg == 4'h1);
    if (nvm_load_start)
      load_cnt_reg <= DLY;
    else if (load_cnt_reg != 4'h0)
      load_cnt_reg <= load_cnt_reg - 4'h1;
    if (cal_start)
      cal_cnt_reg <= DLY;
    else if (cal_cnt_reg != 4'h0)
      cal_cnt_reg <= cal_cnt_reg - 4'h1;
  end
endmodule

// file: testbench/iifs_supervisor_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------
// Port checker of the supervisor
// ------------------------------------------------------
module iifs_props (
  input wire       clock,
  input wire       sys_rst,
  input wire       cmd_write,
  input wire       nvm_write_req,
  input wire       general_write_lock,
  input wire       nvm_write_guard,
  input wire       nvm_load_start,
  input wire       crc_start,
  input wire       cal_start,
  input wire       init_done,
  input wire       bus_accept,
  input wire [6:0] bus_addr,
  input wire       conv_blocked,
  input wire       converting,
  input wire       cmd_write_ok,
  input wire       nvm_write_ok
);
  reg saw_load_reg; // Memory copy was started
  reg saw_crc_reg;  // Check was started
  // Flags survive a supply restart, only reset clears them
  always @(posedge clock) begin
    if (sys_rst) begin
      saw_load_reg <= 1'b0;
      saw_crc_reg  <= 1'b0;
    end else begin
      saw_load_reg <= saw_load_reg | nvm_load_start;
      saw_crc_reg  <= saw_crc_reg | crc_start;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_FALLBACK: assert property (conv_blocked |-> bus_addr == 7'h7C)
    else $error("blocked part not on fallback address");
  AST_BLOCK_NO_CONV: assert property (conv_blocked |-> !converting)
    else $error("blocked part converts");
  AST_CONV_AFTER_INIT: assert property (converting |-> init_done)
    else $error("conversion before init end");
  AST_CMD_READY: assert property (cmd_write_ok |-> $past(bus_accept))
    else $error("write taken before ready");
  AST_CMD_LOCK: assert property (cmd_write_ok |->
    $past(cmd_write && !general_write_lock))
    else $error("locked write taken");
  AST_NVM_GUARD: assert property (nvm_write_ok |->
    $past(nvm_write_req && !nvm_write_guard))
    else $error("guarded memory write taken");
  AST_CRC_ORDER: assert property (crc_start |-> saw_load_reg)
    else $error("check before memory copy");
  AST_CAL_ORDER: assert property (cal_start |-> saw_crc_reg)
    else $error("calibration before check");
  cover property ($rose(init_done));
  cover property (conv_blocked);
  cover property (cmd_write_ok);
  cover property ($fell(converting));
endmodule
bind iifs_supervisor iifs_props i_iifs_props (.clock(clock),
  .sys_rst(sys_rst), .cmd_write(cmd_write), .nvm_write_req(nvm_write_req),
  .general_write_lock(general_write_lock), .nvm_write_guard(nvm_write_guard),
  .nvm_load_start(nvm_load_start), .crc_start(crc_start),
  .cal_start(cal_start), .init_done(init_done), .bus_accept(bus_accept),
  .bus_addr(bus_addr), .conv_blocked(conv_blocked), .converting(converting),
  .cmd_write_ok(cmd_write_ok), .nvm_write_ok(nvm_write_ok));

// file: testbench/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------
// Self-checking bench of the supervisor
// ------------------------------------------------------
module testbench;
  reg        clock, sys_rst, sup, s_ok, c_ok, en, von, uv, ov, pk, clr;
  reg        cwr, nreq, wlk, grd;
  reg        swr, scr, scl, unl, cll;
  reg  [1:0] sel, dat;
  reg  [6:0] sad;
  wire       nls, crs, cls, idn, bac, blk, conv, uvf, ovf, pkf, pnd, cok;
  wire       nok, ldn, cdn;
  wire [6:0] addr;
  wire [7:0] cml;
  integer    mismatches, compares, cyc;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Short init time keeps the run brief
  iifs_supervisor #(.T_INIT_CYC(20), .HICCUP_CYC(8)) i_iifs_supervisor (
    .clock(clock), .sys_rst(sys_rst), .controller_supply_ok(sup),
    .strap_valid(s_ok), .strap_addr(sad), .nvm_load_done(ldn),
    .crc_match(c_ok), .cal_done(cdn), .output_enable_req(en),
    .vin_above_on(von), .vin_under_limit(uv), .vin_over_limit(ov),
    .input_sense_peak(pk), .clear_faults(clr), .cmd_write(cwr),
    .cmd_sel(sel), .cmd_data(dat), .sysreg_write(swr),
    .sysreg_critical(scr), .sysreg_cpu_link(scl), .nvm_write_req(nreq),
    .general_write_lock(wlk), .critical_access_unlock(unl),
    .cpu_link_register_lock(cll), .nvm_write_guard(grd),
    .nvm_load_start(nls), .crc_start(crs), .cal_start(cls),
    .init_done(idn), .bus_accept(bac), .bus_addr(addr),
    .conv_blocked(blk), .converting(conv), .cml_status(cml),
    .vin_uv_fault(uvf), .vin_ov_fault(ovf), .vin_peak_fault(pkf),
    .sysreg_pending(pnd), .cmd_write_ok(cok), .nvm_write_ok(nok));
  iifs_nvm_model i_iifs_nvm_model (.clock(clock), .nvm_load_start(nls),
    .cal_start(cls), .nvm_load_done(ldn), .cal_done(cdn));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  // One strobe; the accept pulse stands in the cycle after it
  task wr(input nv, input lk, input [1:0] s, input [1:0] d, input ex);
    begin
      @(posedge clock);
      wlk <= lk;
      grd <= lk;
      sel <= s;
      dat <= d;
      cwr <= !nv;
      nreq <= nv;
      @(posedge clock);
      cwr <= 1'b0;
      nreq <= 1'b0;
      #1;
      chk(nv ? nok : cok, ex);
    end
  endtask
  // One system register strobe; pending is sticky until a supply cycle
  task sw(input cr, input lk, input un, input cl, input ex);
    begin
      @(posedge clock);
      scr <= cr;
      scl <= lk;
      unl <= un;
      cll <= cl;
      swr <= 1'b1;
      @(posedge clock);
      swr <= 1'b0;
      #1;
      chk(pnd, ex);
    end
  endtask
  task boot(input so, input co);
    integer i;
    begin
      @(posedge clock);
      sys_rst <= 1'b1;
      sup <= 1'b0;
      en <= 1'b0;
      s_ok <= so;
      c_ok <= co;
      tick(4);
      @(posedge clock);
      sys_rst <= 1'b0;
      sup <= 1'b1;
      wr(0, 0, 2'h0, 2'h1, 0);
      for (i = 0; i < 200 && idn !== 1'b1; i = i + 1)
        tick(1);
      chk(idn, 1);
    end
  endtask
  task t_blocked;
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        boot(k != 1, k != 0);
        chk(blk, k != 2);
        chk(addr, k == 2 ? 7'h21 : 7'h7C);
        chk(cml[4], k == 0);
        chk(bac, 1);
        @(posedge clock);
        en <= 1'b1;
        von <= 1'b1;
        tick(8);
        chk(conv, k == 2);
      end
      $display("Test blocked done");
    end
  endtask
  task t_turnon;
    begin
      boot(1, 1);
      @(posedge clock);
      von <= 1'b0;
      en <= 1'b1;
      tick(8);
      chk({conv, uvf}, 2'h1);
      @(posedge clock);
      von <= 1'b1;
      tick(8);
      chk(conv, 1);
      @(posedge clock);
      en <= 1'b0;
      von <= 1'b0;
      tick(8);
      @(posedge clock);
      en <= 1'b1;
      tick(8);
      chk(conv, 1);
      $display("Test turn-on done");
    end
  endtask
  task t_faults;
    begin
      @(posedge clock);
      pk <= 1'b1;
      uv <= 1'b1;
      tick(8);
      chk({conv, pkf}, 2'h3);
      @(posedge clock);
      pk <= 1'b0;
      uv <= 1'b0;
      ov <= 1'b1;
      tick(8);
      @(posedge clock);
      ov <= 1'b0;
      tick(8);
      chk({conv, ovf}, 2'h1);
      @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      tick(2);
      chk(ovf, 0);
      wr(0, 1, 2'h1, 2'h3, 0);
      wr(0, 0, 2'h1, 2'h3, 1);
      wr(1, 1, 2'h0, 2'h0, 0);
      wr(1, 0, 2'h0, 2'h0, 1);
      @(posedge clock);
      en <= 1'b0;
      tick(8);
      @(posedge clock);
      en <= 1'b1;
      tick(8);
      chk(conv, 1);
      @(posedge clock);
      ov <= 1'b1;
      tick(6);
      chk(conv, 0);
      @(posedge clock);
      ov <= 1'b0;
      tick(30);
      chk(conv, 1);
      $display("Test faults done");
    end
  endtask
  // Protected edits, then a supply cycle that applies them
  task t_sysreg;
    integer i;
    begin
      sw(1, 0, 0, 0, 0);
      sw(0, 1, 0, 1, 0);
      sw(1, 0, 1, 0, 1);
      tick(20);
      chk(pnd, 1);
      @(posedge clock);
      sup <= 1'b0;
      tick(8);
      chk({idn, conv}, 2'h0);
      @(posedge clock);
      sup <= 1'b1;
      for (i = 0; i < 200 && idn !== 1'b1; i = i + 1)
        tick(1);
      chk(idn, 1);
      chk(pnd, 0);
      tick(8);
      chk({conv, uvf}, 2'h1);
      $display("Test system register done");
    end
  endtask
  task close_out;
    begin
      $display("Counts: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Hang guard, far above the few hundred cycles the tests use
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  initial begin
    {sys_rst, sup, s_ok, c_ok, en, von, uv, ov, pk, clr} = 10'h200;
    {cwr, nreq, wlk, grd, sel, dat} = 8'h00;
    {swr, scr, scl, unl, cll} = 5'h00;
    sad = 7'h21;
    mismatches = 0;
    compares = 0;
    cyc = 0;
    t_blocked;
    t_turnon;
    t_faults;
    t_sysreg;
    close_out;
  end
endmodule
